// ==== rtl/lscp_top.sv ====
// Legacy system control ports: keyboard and mouse interrupt release,
// coprocessor error port, reset control port and NMI status and control.
// Assumes host I/O cycles arrive as one-cycle strobes already decoded
// from the PCI side, and that timer 2, the refresh engine and the NMI
// mask bit live elsewhere and reach this block as plain levels or pulses.
`timescale 1ns/1ns
module lscp_top #(
  parameter int unsigned HARD_CYCLES = lscp_pkg::HARD_RST_CYCLES,
  parameter int unsigned SOFT_CYCLES = lscp_pkg::SOFT_RST_CYCLES
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          sys_rst_i,
  // Host I/O cycles
  input  wire lscp_pkg::lscp_io_req_t        io_req_i,
  output logic [lscp_pkg::DATA_W-1:0]        io_rdata_o,
  output logic                               io_rvalid_o,
  output logic                               io_claim_o,
  // ISA forwarding
  output lscp_pkg::lscp_isa_cyc_t            isa_cyc_o,
  // Keyboard and mouse interrupts
  input  wire logic                          kbd_irq_i,
  input  wire logic                          mouse_irq_input_i,
  input  wire logic                          mouse_func_en_i,
  output logic                               irq1_o,
  output logic                               irq12_o,
  // Coprocessor error
  input  wire logic                          float_error_n_i,
  output logic                               ignore_numeric_error_n_o,
  output logic                               irq13_o,
  // Resets
  input  wire logic                          power_good_in_i,
  output logic                               cpu_reset_out_o,
  output logic                               pci_reset_n_o,
  output logic                               isa_reset_drive_o,
  output logic                               soft_reset_o,
  // NMI sources and mask
  input  wire logic                          serr_n_i,
  input  wire logic                          iochk_n_i,
  input  wire logic                          nmi_mask_i,
  output logic                               nmi_o,
  // Timer 2, refresh, speaker
  input  wire logic                          counter2_out_i,
  input  wire logic                          refresh_done_i,
  output logic                               counter2_gate_o,
  output logic                               speaker_out_o
);

  // Address decode
  wire hit_kbd   = (io_req_i.addr == lscp_pkg::ADDR_KBD_MOUSE_REL);
  wire hit_nsc   = (io_req_i.addr == lscp_pkg::ADDR_NMI_STS_CTL);
  wire hit_fpu   = (io_req_i.addr == lscp_pkg::ADDR_FPU_ERR_CLR);
  wire hit_rc    = (io_req_i.addr == lscp_pkg::ADDR_RESET_CTL);

  wire rd_kbd    = io_req_i.rd && hit_kbd;
  wire wr_fpu    = io_req_i.wr && hit_fpu;
  wire rd_nsc    = io_req_i.rd && hit_nsc;
  wire wr_nsc    = io_req_i.wr && hit_nsc;
  wire rd_rc     = io_req_i.rd && hit_rc;
  wire wr_rc     = io_req_i.wr && hit_rc;

  // Both ports act here and still travel on to the ISA bus
  wire fwd_cycle = (hit_kbd || hit_fpu) && (io_req_i.rd || io_req_i.wr);

  // Data answered by this block; 60h data comes back from ISA
  wire own_read  = rd_nsc || rd_rc;

  // Keyboard and mouse interrupt latches
  logic kbd_q;
  logic mouse_q;

  wire  kbd_rise   = kbd_irq_i && !kbd_q;
  wire  mouse_rise = mouse_irq_input_i && !mouse_q && mouse_func_en_i;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      kbd_q   <= 1'b0;
      mouse_q <= 1'b0;
    end else begin
      kbd_q   <= kbd_irq_i;
      mouse_q <= mouse_irq_input_i;
    end
  end

  // A fresh edge in the release cycle wins over the release
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq1_o <= 1'b0;
    end else if (kbd_rise) begin
      irq1_o <= 1'b1;
    end else if (rd_kbd) begin
      irq1_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq12_o <= 1'b0;
    end else if (!mouse_func_en_i) begin
      irq12_o <= 1'b0;
    end else if (mouse_rise) begin
      irq12_o <= 1'b1;
    end else if (rd_kbd) begin
      irq12_o <= 1'b0;
    end
  end

  // Coprocessor error handling
  logic float_error_in_q;
  logic ign_req;

  wire  float_error_in_active = !float_error_n_i;
  wire  float_error_in_rise   = float_error_in_active && !float_error_in_q;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      float_error_in_q <= 1'b0;
    end else begin
      float_error_in_q <= float_error_in_active;
    end
  end

  // IRQ13 raised by a new float error, dropped by the clear port
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq13_o <= 1'b0;
    end else if (float_error_in_rise) begin
      irq13_o <= 1'b1;
    end else if (wr_fpu) begin
      irq13_o <= 1'b0;
    end
  end

  // Ignore request ends once the error goes away
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ign_req <= 1'b0;
    end else if (!float_error_in_active) begin
      ign_req <= 1'b0;
    end else if (wr_fpu) begin
      ign_req <= 1'b1;
    end
  end

  wire next_ign_n = !(ign_req && float_error_in_active);

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ignore_numeric_error_n_o <= 1'b1;
    end else begin
      ignore_numeric_error_n_o <= next_ign_n;
    end
  end

  // Reset control port
  logic reset_type_bit;
  logic reset_initiate_bit;

  wire  wr_init     = io_req_i.wdata[lscp_pkg::RC_INITIATE];
  wire  wr_type     = io_req_i.wdata[lscp_pkg::RC_TYPE];
  wire  init_rise   = wr_rc && wr_init && !reset_initiate_bit;
  // Type written in the same cycle as the initiate edge is honoured
  wire  hard_by_reg = init_rise && wr_type;
  wire  soft_by_reg = init_rise && !wr_type;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reset_type_bit     <= lscp_pkg::RC_RESET_VAL[lscp_pkg::RC_TYPE];
      reset_initiate_bit <= lscp_pkg::RC_RESET_VAL[lscp_pkg::RC_INITIATE];
    end else if (wr_rc) begin
      reset_type_bit     <= wr_type;
      reset_initiate_bit <= wr_init;
    end
  end

  // Initiate stays stored, so a repeated 04h starts nothing
  wire [lscp_pkg::DATA_W-1:0] rc_view;

  assign rc_view = {5'h00, 1'b0, reset_type_bit, 1'b0};

  lscp_reset_seq #(
    .HARD_CYCLES (HARD_CYCLES),
    .SOFT_CYCLES (SOFT_CYCLES)
  ) u_reset_seq (
    .core_clk_i        (core_clk_i),
    .sys_rst_i         (sys_rst_i),
    .hard_req_i        (hard_by_reg),
    .soft_req_i        (soft_by_reg),
    .power_good_i      (power_good_in_i),
    .cpu_reset_o       (cpu_reset_out_o),
    .pci_reset_n_o     (pci_reset_n_o),
    .isa_reset_drive_o (isa_reset_drive_o),
    .soft_reset_o      (soft_reset_o)
  );

  // NMI status and control port
  logic iochk_dis;
  logic serr_dis;
  logic speaker_out_en;
  logic tmr2_gate;
  logic refresh_tgl;

  // Software is expected to write zeros in 7..4; those bits ignore writes
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      iochk_dis <= lscp_pkg::NSC_RESET_VAL[lscp_pkg::NSC_IOCHK_DIS];
      serr_dis  <= lscp_pkg::NSC_RESET_VAL[lscp_pkg::NSC_SERR_DIS];
      speaker_out_en   <= lscp_pkg::NSC_RESET_VAL[lscp_pkg::NSC_SPEAKER_OUT_EN];
      tmr2_gate <= lscp_pkg::NSC_RESET_VAL[lscp_pkg::NSC_TMR2_GATE];
    end else if (wr_nsc) begin
      iochk_dis <= io_req_i.wdata[lscp_pkg::NSC_IOCHK_DIS];
      serr_dis  <= io_req_i.wdata[lscp_pkg::NSC_SERR_DIS];
      speaker_out_en   <= io_req_i.wdata[lscp_pkg::NSC_SPEAKER_OUT_EN];
      tmr2_gate <= io_req_i.wdata[lscp_pkg::NSC_TMR2_GATE];
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      refresh_tgl <= lscp_pkg::NSC_RESET_VAL[lscp_pkg::NSC_REFRESH];
    end else if (refresh_done_i) begin
      refresh_tgl <= !refresh_tgl;
    end
  end

  wire [lscp_pkg::NMI_SRC_NUM-1:0] src_n;
  wire [lscp_pkg::NMI_SRC_NUM-1:0] src_dis;
  wire [lscp_pkg::NMI_SRC_NUM-1:0] src_sts;

  assign src_n[lscp_pkg::NMI_SRC_SERR]    = serr_n_i;
  assign src_n[lscp_pkg::NMI_SRC_IOCHK]   = iochk_n_i;
  assign src_dis[lscp_pkg::NMI_SRC_SERR]  = serr_dis;
  assign src_dis[lscp_pkg::NMI_SRC_IOCHK] = iochk_dis;

  lscp_nmi_src #(
    .NUM (lscp_pkg::NMI_SRC_NUM)
  ) u_nmi_src (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .src_n_i    (src_n),
    .disable_i  (src_dis),
    .status_o   (src_sts)
  );

  wire serr_sts  = src_sts[lscp_pkg::NMI_SRC_SERR];
  wire iochk_sts = src_sts[lscp_pkg::NMI_SRC_IOCHK];

  // Level output: a mask pulse drops it so the CPU sees a new edge
  wire next_nmi  = ((serr_sts && !serr_dis) || (iochk_sts && !iochk_dis)) && !nmi_mask_i;

  wire [lscp_pkg::DATA_W-1:0] nsc_view;

  assign nsc_view = {serr_sts,
                     iochk_sts,
                     counter2_out_i,
                     refresh_tgl,
                     iochk_dis,
                     serr_dis,
                     speaker_out_en,
                     tmr2_gate};

  wire [lscp_pkg::DATA_W-1:0] next_rdata = rd_nsc ? nsc_view :
                                           rd_rc  ? rc_view  :
                                                    lscp_pkg::READ_ZERO;

  // Outputs
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nmi_o           <= 1'b0;
      speaker_out_o   <= 1'b0;
      counter2_gate_o <= 1'b0;
    end else begin
      nmi_o           <= next_nmi;
      speaker_out_o   <= speaker_out_en && counter2_out_i;
      counter2_gate_o <= tmr2_gate;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_rdata_o  <= lscp_pkg::READ_ZERO;
      io_rvalid_o <= 1'b0;
      io_claim_o  <= 1'b0;
    end else begin
      io_rdata_o  <= next_rdata;
      io_rvalid_o <= io_req_i.rd;
      io_claim_o  <= own_read;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      isa_cyc_o <= '0;
    end else begin
      isa_cyc_o.addr  <= io_req_i.addr;
      isa_cyc_o.wdata <= io_req_i.wdata;
      isa_cyc_o.rd    <= fwd_cycle && io_req_i.rd;
      isa_cyc_o.wr    <= fwd_cycle && io_req_i.wr;
    end
  end

endmodule : lscp_top

// ==== rtl/lscp_pkg.sv ====
// Shared constants and carrier types for the legacy system control ports.
// Assumes a host I/O cycle source giving one-cycle read and write strobes.
// Function
// - Read of 60h clears keyboard, mouse interrupts
// - Enabled mouse input drives IRQ12
// - Ports 60h and F0h forwarded onto ISA
// - Write F0h asserts ignore-error, drops IRQ13
// - Ignore-error only while float error active
// - Reset starts on initiate bit rising
// - Type bit selects hard or soft reset
// - Hard reset drives CPU, PCI, ISA resets
// - Power-good assertion also forces hard reset
// - Initiate bit always reads back zero
// - Enabled system-error pulse sets status bit 7
// - Enabled channel-check sets status bit 6
// - Bit 3 one clears, disables channel-check
// - Bit 2 one clears, disables system-error
// - Bit 5 shows live timer 2 output
// - Bit 4 toggles after each refresh
// - Bit 1 gates timer 2 onto speaker
// - Bit 0 gates timer 2; port resets 00h
// - NMI held high while enabled source pending
// - Mask then unmask gives fresh NMI edge
package lscp_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_KBD_MOUSE_REL = 16'h0060;
  localparam logic [ADDR_W-1:0] ADDR_NMI_STS_CTL   = 16'h0061;
  localparam logic [ADDR_W-1:0] ADDR_FPU_ERR_CLR   = 16'h00f0;
  localparam logic [ADDR_W-1:0] ADDR_RESET_CTL     = 16'h0cf9;

  localparam int unsigned NSC_SERR_STS  = 7;
  localparam int unsigned NSC_IOCHK_STS = 6;
  localparam int unsigned NSC_TMR2_OUT  = 5;
  localparam int unsigned NSC_REFRESH   = 4;
  localparam int unsigned NSC_IOCHK_DIS = 3;
  localparam int unsigned NSC_SERR_DIS  = 2;
  localparam int unsigned NSC_SPEAKER_OUT_EN   = 1;
  localparam int unsigned NSC_TMR2_GATE = 0;

  localparam int unsigned RC_INITIATE = 2;
  localparam int unsigned RC_TYPE     = 1;

  localparam logic [DATA_W-1:0] NSC_RESET_VAL = 8'h00;
  localparam logic [DATA_W-1:0] RC_RESET_VAL  = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO     = 8'h00;

  // Source index inside the NMI latch pair
  localparam int unsigned NMI_SRC_SERR  = 0;
  localparam int unsigned NMI_SRC_IOCHK = 1;
  localparam int unsigned NMI_SRC_NUM   = 2;

  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned HARD_RST_TIME_NS = 1000;
  localparam int unsigned SOFT_RST_TIME_NS = 500;
  localparam int unsigned HARD_RST_CYCLES  = (HARD_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_RST_CYCLES  = (SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } lscp_io_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } lscp_isa_cyc_t;

  typedef enum logic [1:0] {
    RST_IDLE,
    RST_HARD,
    RST_SOFT
  } lscp_rst_state_t;

endpackage : lscp_pkg

// ==== rtl/lscp_nmi_src.sv ====
// Latched NMI source status bits, one per source.
// Assumes active-low source inputs synchronous to core_clk_i.
`timescale 1ns/1ns
module lscp_nmi_src #(
  parameter int unsigned NUM = lscp_pkg::NMI_SRC_NUM
) (
  input  wire logic           core_clk_i,
  input  wire logic           sys_rst_i,
  input  wire logic [NUM-1:0] src_n_i,
  input  wire logic [NUM-1:0] disable_i,
  output logic      [NUM-1:0] status_o
);

  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : g_src
      wire next_set = !src_n_i[g] && !disable_i[g];
      always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          status_o[g] <= 1'b0;
        end else if (disable_i[g]) begin
          // Disable holds the bit clear, so set and clear never meet
          status_o[g] <= 1'b0;
        end else if (next_set) begin
          status_o[g] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule : lscp_nmi_src

// ==== rtl/lscp_reset_seq.sv ====
// Hard and soft reset sequencer.
// Assumes one-cycle request pulses and a synchronous power-good level.
`timescale 1ns/1ns
module lscp_reset_seq #(
  parameter int unsigned HARD_CYCLES = lscp_pkg::HARD_RST_CYCLES,
  parameter int unsigned SOFT_CYCLES = lscp_pkg::SOFT_RST_CYCLES,
  parameter int unsigned CNT_W       = 16
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic hard_req_i,
  input  wire logic soft_req_i,
  input  wire logic power_good_i,
  output logic      cpu_reset_o,
  output logic      pci_reset_n_o,
  output logic      isa_reset_drive_o,
  output logic      soft_reset_o
);

  lscp_pkg::lscp_rst_state_t state;
  lscp_pkg::lscp_rst_state_t next_state;
  logic [CNT_W-1:0]          cnt;
  logic [CNT_W-1:0]          next_cnt;
  logic                      pg_q;

  wire pg_rise  = power_good_i && !pg_q;
  wire cnt_done = (cnt == '0);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      lscp_pkg::RST_IDLE: begin
        // Power-good low holds the system in hard reset
        if (!power_good_i || pg_rise || hard_req_i) begin
          next_state = lscp_pkg::RST_HARD;
          next_cnt   = CNT_W'(HARD_CYCLES - 1);
        end else if (soft_req_i) begin
          next_state = lscp_pkg::RST_SOFT;
          next_cnt   = CNT_W'(SOFT_CYCLES - 1);
        end
      end
      lscp_pkg::RST_HARD: begin
        if (!power_good_i) begin
          next_cnt = CNT_W'(HARD_CYCLES - 1);
        end else if (cnt_done) begin
          next_state = lscp_pkg::RST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      lscp_pkg::RST_SOFT: begin
        if (!power_good_i || pg_rise || hard_req_i) begin
          next_state = lscp_pkg::RST_HARD;
          next_cnt   = CNT_W'(HARD_CYCLES - 1);
        end else if (cnt_done) begin
          next_state = lscp_pkg::RST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = lscp_pkg::RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= lscp_pkg::RST_HARD;
      cnt   <= '0;
      pg_q  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      pg_q  <= power_good_i;
    end
  end

  wire hard_now = (state == lscp_pkg::RST_HARD);

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cpu_reset_o       <= 1'b1;
      pci_reset_n_o     <= 1'b0;
      isa_reset_drive_o <= 1'b1;
      soft_reset_o      <= 1'b0;
    end else begin
      cpu_reset_o       <= (next_state == lscp_pkg::RST_HARD);
      pci_reset_n_o     <= !(next_state == lscp_pkg::RST_HARD);
      isa_reset_drive_o <= (next_state == lscp_pkg::RST_HARD);
      soft_reset_o      <= (next_state == lscp_pkg::RST_SOFT) && !hard_now;
    end
  end

endmodule : lscp_reset_seq

// ==== sim/lscp_props.sv ====
// Concurrent checks on the legacy system control ports, seen at the top ports.
// Assumes one clock domain and the top module's default parameters being irrelevant here.
`timescale 1ns/1ns
module lscp_props (
  input wire logic                    core_clk_i,
  input wire logic                    sys_rst_i,
  input wire lscp_pkg::lscp_io_req_t  io_req_i,
  input wire logic [7:0]              io_rdata_o,
  input wire logic                    io_rvalid_o,
  input wire logic                    io_claim_o,
  input wire lscp_pkg::lscp_isa_cyc_t isa_cyc_o,
  input wire logic                    kbd_irq_i,
  input wire logic                    mouse_irq_input_i,
  input wire logic                    mouse_func_en_i,
  input wire logic                    irq1_o,
  input wire logic                    irq12_o,
  input wire logic                    float_error_n_i,
  input wire logic                    ignore_numeric_error_n_o,
  input wire logic                    irq13_o,
  input wire logic                    power_good_in_i,
  input wire logic                    cpu_reset_out_o,
  input wire logic                    pci_reset_n_o,
  input wire logic                    isa_reset_drive_o,
  input wire logic                    soft_reset_o,
  input wire logic                    nmi_mask_i,
  input wire logic                    nmi_o,
  input wire logic                    counter2_out_i,
  input wire logic                    speaker_out_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  wire rd_kbd = io_req_i.rd && io_req_i.addr == lscp_pkg::ADDR_KBD_MOUSE_REL;
  wire wr_fpu = io_req_i.wr && io_req_i.addr == lscp_pkg::ADDR_FPU_ERR_CLR;
  wire wr_rc  = io_req_i.wr && io_req_i.addr == lscp_pkg::ADDR_RESET_CTL;

  // Sources held low so no set competes with the release
  a_kbd_release: assert property (rd_kbd && !kbd_irq_i && !mouse_irq_input_i |=> !irq1_o && !irq12_o)
    else $error("keyboard or mouse irq not released");
  a_mouse_gated: assert property (!mouse_func_en_i |=> !irq12_o)
    else $error("mouse irq passed while disabled");
  a_isa_forward: assert property (wr_fpu |=> isa_cyc_o.wr && isa_cyc_o.addr == lscp_pkg::ADDR_FPU_ERR_CLR)
    else $error("coprocessor write not forwarded");
  a_fpu_clear: assert property (wr_fpu && float_error_n_i == $past(float_error_n_i) |=> !irq13_o)
    else $error("irq13 not dropped");
  a_ignore_needs_err: assert property (!ignore_numeric_error_n_o |-> !$past(float_error_n_i))
    else $error("ignore-error without float error");
  a_soft_cause: assert property ($rose(soft_reset_o) |-> $past(wr_rc && io_req_i.wdata[2]))
    else $error("soft reset without initiate write");
  a_reset_trio: assert property (cpu_reset_out_o == isa_reset_drive_o && pci_reset_n_o == !cpu_reset_out_o)
    else $error("reset outputs disagree");
  a_power_low_holds: assert property (!power_good_in_i |=> cpu_reset_out_o)
    else $error("power-good low without hard reset");
  a_rc_bit2_zero: assert property ($past(io_req_i.rd) && $past(io_req_i.addr) == lscp_pkg::ADDR_RESET_CTL
                                   |-> io_rvalid_o && io_claim_o && !io_rdata_o[2])
    else $error("reset control read shows initiate bit");
  a_speaker_follow: assert property (speaker_out_o |-> $past(counter2_out_i))
    else $error("speaker high without timer output");
  a_mask_drops: assert property (nmi_mask_i |=> !nmi_o)
    else $error("nmi high while masked");

  c_soft: cover property ($rose(soft_reset_o));
  c_hard: cover property ($rose(cpu_reset_out_o));
  c_nmi:  cover property ($rose(nmi_o));
endmodule : lscp_props

bind lscp_top lscp_props u_props (.core_clk_i, .sys_rst_i, .io_req_i, .io_rdata_o, .io_rvalid_o, .io_claim_o,
  .isa_cyc_o, .kbd_irq_i, .mouse_irq_input_i, .mouse_func_en_i, .irq1_o, .irq12_o, .float_error_n_i,
  .ignore_numeric_error_n_o, .irq13_o, .power_good_in_i, .cpu_reset_out_o, .pci_reset_n_o,
  .isa_reset_drive_o, .soft_reset_o, .nmi_mask_i, .nmi_o, .counter2_out_i, .speaker_out_o);

// ==== sim/lscp_host_model.sv ====
// Host CPU model issuing single-byte I/O reads and writes as one-cycle strobes.
// Assumes its tasks are called from one bench process only.
`timescale 1ns/1ns
module lscp_host_model (
  input  wire logic               core_clk_i,
  input  wire logic [7:0]         io_rdata_i,
  output lscp_pkg::lscp_io_req_t  io_req_o
);
  initial io_req_o = '0;

  // Address and data flip after each cycle so stale values never look valid
  task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
    if (addr == lscp_pkg::ADDR_NMI_STS_CTL) data[7:4] = 4'h0;
    @(posedge core_clk_i);
    io_req_o <= '{addr: addr, rd: 1'h0, wr: 1'h1, wdata: data};
    @(posedge core_clk_i);
    io_req_o <= '{addr: ~addr, rd: 1'h0, wr: 1'h0, wdata: ~data};
    #1;
  endtask : io_write

  task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
    @(posedge core_clk_i);
    io_req_o <= '{addr: addr, rd: 1'h1, wr: 1'h0, wdata: 8'h00};
    @(posedge core_clk_i);
    io_req_o <= '{addr: ~addr, rd: 1'h0, wr: 1'h0, wdata: 8'hff};
    #1;
    data = io_rdata_i;
  endtask : io_read
endmodule : lscp_host_model

// ==== sim/tb.sv ====
// Self-checking bench for the legacy system control ports.
// Assumes the host model drives all I/O cycles; reset lengths shortened to 2.
`timescale 1ns/1ns
module tb;
  logic                    core_clk_i = 1'h0;
  logic                    sys_rst_i  = 1'h1;
  lscp_pkg::lscp_io_req_t  io_req_i;
  lscp_pkg::lscp_isa_cyc_t isa_cyc_o;
  logic [7:0]              io_rdata_o;
  logic [7:0]              rd_val;
  logic io_rvalid_o, io_claim_o, irq1_o, irq12_o, ignore_numeric_error_n_o, irq13_o, nmi_o;
  logic cpu_reset_out_o, pci_reset_n_o, isa_reset_drive_o, soft_reset_o, counter2_gate_o, speaker_out_o;
  logic kbd_irq_i = 1'h0, mouse_irq_input_i = 1'h0, mouse_func_en_i = 1'h1, float_error_n_i = 1'h1;
  logic power_good_in_i = 1'h1, serr_n_i = 1'h1, iochk_n_i = 1'h1, nmi_mask_i = 1'h0;
  logic counter2_out_i = 1'h0, refresh_done_i = 1'h0;
  int   n_mismatch = 0;
  int   n_compared = 0;

  always #25 core_clk_i = ~core_clk_i;

  lscp_top #(.HARD_CYCLES(2), .SOFT_CYCLES(2)) dut (.core_clk_i, .sys_rst_i, .io_req_i, .io_rdata_o,
    .io_rvalid_o, .io_claim_o, .isa_cyc_o, .kbd_irq_i, .mouse_irq_input_i, .mouse_func_en_i, .irq1_o,
    .irq12_o, .float_error_n_i, .ignore_numeric_error_n_o, .irq13_o, .power_good_in_i, .cpu_reset_out_o,
    .pci_reset_n_o, .isa_reset_drive_o, .soft_reset_o, .serr_n_i, .iochk_n_i, .nmi_mask_i, .nmi_o,
    .counter2_out_i, .refresh_done_i, .counter2_gate_o, .speaker_out_o);

  lscp_host_model host (.core_clk_i, .io_rdata_i(io_rdata_o), .io_req_o(io_req_i));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task automatic rdc(input logic [15:0] addr, input logic [7:0] exp);
    host.io_read(addr, rd_val);
    chk(rd_val, exp);
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc

  task automatic src_pulse(input logic serr);
    @(posedge core_clk_i) if (serr) serr_n_i <= 1'h0; else iochk_n_i <= 1'h0;
    @(posedge core_clk_i) begin serr_n_i <= 1'h1; iochk_n_i <= 1'h1; end
    cyc(2);
  endtask : src_pulse

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // Whole run is about 120 cycles; 3000 cycles, some 25 times that, means a hang
  initial begin
    #(3000 * 50);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'h0;
    cyc(3);
    rdc(16'h0061, 8'h00);
    rdc(16'h0cf9, 8'h00);
    @(posedge core_clk_i) begin kbd_irq_i <= 1'h1; mouse_irq_input_i <= 1'h1; end
    cyc(2);
    chk({6'h00, irq1_o, irq12_o}, 8'h03);
    @(posedge core_clk_i) begin kbd_irq_i <= 1'h0; mouse_irq_input_i <= 1'h0; end
    host.io_read(16'h0060, rd_val);
    chk1(isa_cyc_o.rd, 1'h1);
    chk({6'h00, io_rvalid_o, io_claim_o}, 8'h02);
    chk({6'h00, irq1_o, irq12_o}, 8'h00);
    @(posedge core_clk_i) begin mouse_func_en_i <= 1'h0; mouse_irq_input_i <= 1'h1; end
    cyc(2);
    chk1(irq12_o, 1'h0);
    @(posedge core_clk_i) begin mouse_func_en_i <= 1'h1; mouse_irq_input_i <= 1'h0; float_error_n_i <= 1'h0; end
    cyc(2);
    chk1(irq13_o, 1'h1);
    host.io_write(16'h00f0, 8'h5a);
    chk1(isa_cyc_o.wr, 1'h1);
    chk1(irq13_o, 1'h0);
    cyc(1);
    chk1(ignore_numeric_error_n_o, 1'h0);
    @(posedge core_clk_i) float_error_n_i <= 1'h1;
    cyc(2);
    chk1(ignore_numeric_error_n_o, 1'h1);
    host.io_write(16'h00f0, 8'ha5);
    cyc(1);
    chk1(ignore_numeric_error_n_o, 1'h1);
    @(posedge core_clk_i) counter2_out_i <= 1'h1;
    host.io_write(16'h0061, 8'hf3);
    cyc(1);
    chk({6'h00, speaker_out_o, counter2_gate_o}, 8'h03);
    rdc(16'h0061, 8'h23);
    @(posedge core_clk_i) refresh_done_i <= 1'h1;
    @(posedge core_clk_i) refresh_done_i <= 1'h0;
    cyc(1);
    rdc(16'h0061, 8'h33);
    @(posedge core_clk_i) counter2_out_i <= 1'h0;
    cyc(2);
    chk1(speaker_out_o, 1'h0);
    host.io_write(16'h0061, 8'h00);
    src_pulse(1'h1);
    chk1(nmi_o, 1'h1);
    rdc(16'h0061, 8'h90);
    @(posedge core_clk_i) nmi_mask_i <= 1'h1;
    @(posedge core_clk_i) nmi_mask_i <= 1'h0;
    #1 chk1(nmi_o, 1'h0);
    cyc(1);
    chk1(nmi_o, 1'h1);
    host.io_write(16'h0061, 8'h04);
    cyc(1);
    chk1(nmi_o, 1'h0);
    src_pulse(1'h1);
    rdc(16'h0061, 8'h14);
    host.io_write(16'h0061, 8'h08);
    src_pulse(1'h0);
    chk1(nmi_o, 1'h0);
    host.io_write(16'h0061, 8'h00);
    src_pulse(1'h0);
    chk1(nmi_o, 1'h1);
    rdc(16'h0061, 8'h50);
    host.io_write(16'h0061, 8'h08);
    rdc(16'h0061, 8'h18);
    host.io_write(16'h0cf9, 8'h00);
    host.io_write(16'h0cf9, 8'h04);
    chk({6'h00, cpu_reset_out_o, soft_reset_o}, 8'h01);
    rdc(16'h0cf9, 8'h00);
    chk1(soft_reset_o, 1'h0);
    cyc(4);
    host.io_write(16'h0cf9, 8'h04);
    chk1(soft_reset_o, 1'h0);
    host.io_write(16'h0cf9, 8'h02);
    rdc(16'h0cf9, 8'h02);
    host.io_write(16'h0cf9, 8'h06);
    chk({5'h00, cpu_reset_out_o, pci_reset_n_o, isa_reset_drive_o}, 8'h05);
    cyc(6);
    chk1(cpu_reset_out_o, 1'h0);
    @(posedge core_clk_i) power_good_in_i <= 1'h0;
    cyc(3);
    chk1(cpu_reset_out_o, 1'h1);
    @(posedge core_clk_i) power_good_in_i <= 1'h1;
    cyc(6);
    chk1(cpu_reset_out_o, 1'h0);
    print_verdict();
  end
endmodule : tb
